/* File: include/fes_defs.vh */
// Constants for the flash erase, suspend, power-down and ID sequencer
`ifndef FES_DEFS_VH
`define FES_DEFS_VH
// =========================================================
// Opcodes
`define FES_OP_WR_ENABLE 8'h06
`define FES_OP_RDSR1    8'h05
`define FES_OP_RDSR2    8'h35
`define FES_OP_ERASE4K  8'h20
`define FES_OP_ERASE32K 8'h52
`define FES_OP_ERASE64K 8'hd8
`define FES_OP_CHIPA    8'hc7
`define FES_OP_CHIPB    8'h60
`define FES_OP_SUSPEND  8'h75
`define FES_OP_RESUME   8'h7a
`define FES_OP_DEEPPD   8'hb9
`define FES_OP_RELEASE  8'hab
`define FES_OP_MFGID    8'h90
// =========================================================
// Byte counts of complete commands, and the data-phase byte count that wraps back
`define FES_BYTES_BARE  3'h1
`define FES_BYTES_ADDR  3'h4
`define FES_BYTE_WRAP   3'h7
// =========================================================
// Operation kinds
`define FES_KIND_4K     3'h0
`define FES_KIND_32K    3'h1
`define FES_KIND_64K    3'h2
`define FES_KIND_CHIP   3'h3
`define FES_KIND_PROG   3'h4
// =========================================================
// Block boundaries (lowest kept address bit)
`define FES_LSB_4K      12
`define FES_LSB_32K     15
`define FES_LSB_64K     16
// =========================================================
// Timing
`define FES_CLK_MHZ     20
`define FES_SUSPEND_NS  20000
`define FES_DP_NS       3000
`define FES_RES1_NS     3000
`define FES_RESUME_NS   200
`endif

/* File: rtl/fes_core.v */
// Serial flash command sequencer: erase, suspend, power-down, ID reads
// Summary of operation
// - Opcode 20h plus 24-bit address erases one 4 kB block to ones.
// - Opcode 52h plus address erases one 32 kB block to ones.
// - Opcode D8h plus address erases one 64 kB block to ones.
// - Opcode C7h or 60h without address erases the whole array.
// - Erase runs only if chip select rises on the final byte edge.
// - Busy high during erase, latch cleared then, status stays readable.
// - Suspend is ignored while a chip erase runs.
// - Erase suspended: status writes and all erases refused.
// - Program suspended: status writes, programs and erases refused.
// - Suspend accepted only with flag clear, busy, block erase or program.
// - Accepted suspend sets flag at once, drops busy within latency.
// - Resume with flag set and not busy: clear flag, busy in 200 ns.
// - Resume ignored while flag clear or busy.
// - Power loss clears suspend state; later resume is refused.
// - B9h alone, select rising after its eighth bit, enters deep power-down after entry delay.
// - Deep power-down only honours ABh; power-up lands in standby.
// - Bare ABh releases power-down; commands wait out recovery time.
// - ABh plus three dummies streams the device ID, SPI mode only.
// - ABh while busy is ignored and leaves the operation alone.
// - 90h streams maker then device byte; address 1 starts with device.
// - Write enable command sets the write enable latch.
`timescale 1ns/10ps
`include "fes_defs.vh"

module fes_core #(
  parameter P_SMALL_ERASE_US = 1000,
  parameter P_MID_ERASE_US   = 3000,
  parameter P_LARGE_ERASE_US = 5000,
  parameter P_FULL_ERASE_US  = 40000,
  parameter P_PROG_US        = 600,
  // Identity bytes: arbitrary values
  parameter [7:0] P_MFG_ID   = 8'ha5,
  parameter [7:0] P_DEV_ID   = 8'h3c
) (
  input  wire        I_CLOCK,
  input  wire        I_RST_N,
  input  wire        I_SCK,
  input  wire        I_CS_N,
  input  wire        I_SI,
  input  wire        I_QUAD_COMMAND_MODE,
  input  wire        I_PROG_START,
  output wire        O_SO,
  output wire        O_SO_OE,
  output wire        O_BUSY,
  output wire        O_WRITE_ENABLE_LATCH,
  output wire        O_SUSPEND_FLAG,
  output wire        O_DEEP_POWER_DOWN,
  output wire        O_PROG_ALLOW,
  output wire        O_STATUS_WRITE_ALLOW,
  output wire        O_OP_DONE,
  output wire [2:0]  O_OP_KIND,
  output wire [23:0] O_ERASE_BASE
);

  // =========================================================
  // Cycle counts
  localparam [31:0] C_SMALL = P_SMALL_ERASE_US * `FES_CLK_MHZ;
  localparam [31:0] C_MID   = P_MID_ERASE_US * `FES_CLK_MHZ;
  localparam [31:0] C_LARGE = P_LARGE_ERASE_US * `FES_CLK_MHZ;
  localparam [31:0] C_FULL  = P_FULL_ERASE_US * `FES_CLK_MHZ;
  localparam [31:0] C_PROG  = P_PROG_US * `FES_CLK_MHZ;
  // Latencies worked out at full width, then cut to the counter width
  localparam [31:0] W_SUS   = (`FES_SUSPEND_NS * `FES_CLK_MHZ) / 1000;
  localparam [31:0] W_DP    = (`FES_DP_NS * `FES_CLK_MHZ + 999) / 1000;
  localparam [31:0] W_RES1  = (`FES_RES1_NS * `FES_CLK_MHZ + 999) / 1000;
  localparam [15:0] C_SUS   = W_SUS[15:0];
  localparam [15:0] C_DP    = W_DP[15:0];
  localparam [15:0] C_RES1  = W_RES1[15:0];

  localparam [6:0] ST_IDLE    = 7'h01;
  localparam [6:0] ST_RUN     = 7'h02;
  localparam [6:0] ST_SUSPEND = 7'h04;
  localparam [6:0] ST_HELD    = 7'h08;
  localparam [6:0] ST_PDENTER = 7'h10;
  localparam [6:0] ST_DEEP    = 7'h20;
  localparam [6:0] ST_RELEASE = 7'h40;

  // =========================================================
  // Pin synchronisers
  reg [2:0] sck_reg;
  reg [2:0] cs_reg;
  reg [1:0] si_reg;

  always @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      sck_reg <= 3'h0;
      cs_reg  <= 3'h7;
      si_reg  <= 2'h0;
    end else begin
      sck_reg <= {sck_reg[1:0], I_SCK};
      cs_reg  <= {cs_reg[1:0], I_CS_N};
      si_reg  <= {si_reg[0], I_SI};
    end
  end

  wire cs_low  = ~cs_reg[1];
  wire sck_up  = cs_low & sck_reg[1] & ~sck_reg[2];
  wire sck_dn  = cs_low & ~sck_reg[1] & sck_reg[2];
  wire cs_rise = cs_reg[1] & ~cs_reg[2];
  wire si_bit  = si_reg[1];

  // =========================================================
  // Serial shifter
  reg [2:0]  bit_cnt_reg;
  reg [2:0]  byte_cnt_reg;
  reg [6:0]  shift_reg;
  reg [7:0]  op_reg;
  reg [23:0] addr_reg;

  always @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 3'h0;
      shift_reg    <= 7'h00;
      op_reg       <= 8'h00;
      addr_reg     <= 24'h000000;
    end else if (!cs_low) begin
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 3'h0;
    end else if (sck_up) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg   <= {shift_reg[5:0], si_bit};
      if (byte_cnt_reg != 3'h0 && byte_cnt_reg < `FES_BYTES_ADDR)
        addr_reg <= {addr_reg[22:0], si_bit};
      if (bit_cnt_reg == 3'h7) begin
        if (byte_cnt_reg == 3'h0)
          op_reg <= {shift_reg, si_bit};
        // Data phase keeps alternating parity for the ID streams
        if (byte_cnt_reg == `FES_BYTE_WRAP)
          byte_cnt_reg <= `FES_BYTES_ADDR;
        else
          byte_cnt_reg <= byte_cnt_reg + 3'h1;
      end
    end
  end

  // =========================================================
  // Operation state
  reg [6:0]  state_reg;
  reg [31:0] op_cnt_reg;
  reg [15:0] lat_cnt_reg;
  reg [2:0]  kind_reg;
  reg [23:0] base_reg;
  reg        latch_reg;
  reg        suspend_reg;
  reg        done_reg;

  wire busy     = (state_reg == ST_RUN) || (state_reg == ST_SUSPEND);
  wire deep     = (state_reg == ST_PDENTER) || (state_reg == ST_DEEP) ||
                  (state_reg == ST_RELEASE);
  wire bare_end = (bit_cnt_reg == 3'h0) &&
                  (byte_cnt_reg == `FES_BYTES_BARE);
  wire addr_end = (bit_cnt_reg == 3'h0) &&
                  (byte_cnt_reg == `FES_BYTES_ADDR);
  wire is_blk   = (op_reg == `FES_OP_ERASE4K) ||
                  (op_reg == `FES_OP_ERASE32K) ||
                  (op_reg == `FES_OP_ERASE64K);
  wire is_chip  = (op_reg == `FES_OP_CHIPA) || (op_reg == `FES_OP_CHIPB);

  reg [2:0]  new_kind;
  reg [23:0] new_base;
  reg [31:0] new_cnt;

  always @* begin
    new_kind = `FES_KIND_CHIP;
    new_base = 24'h000000;
    new_cnt  = C_FULL;
    case (op_reg)
      `FES_OP_ERASE4K: begin
        new_kind = `FES_KIND_4K;
        new_base = (addr_reg >> `FES_LSB_4K) << `FES_LSB_4K;
        new_cnt  = C_SMALL;
      end
      `FES_OP_ERASE32K: begin
        new_kind = `FES_KIND_32K;
        new_base = (addr_reg >> `FES_LSB_32K) << `FES_LSB_32K;
        new_cnt  = C_MID;
      end
      `FES_OP_ERASE64K: begin
        new_kind = `FES_KIND_64K;
        new_base = (addr_reg >> `FES_LSB_64K) << `FES_LSB_64K;
        new_cnt  = C_LARGE;
      end
      default: begin
        new_kind = `FES_KIND_CHIP;
      end
    endcase
  end

  // Exact chip select edge; latch needed; no suspend
  wire erase_ok = cs_rise && latch_reg && (state_reg == ST_IDLE) &&
                  !suspend_reg &&
                  ((is_blk && addr_end) || (is_chip && bare_end));

  always @(posedge I_CLOCK) begin
    // Power loss acts as reset: suspend dropped
    if (!I_RST_N) begin
      state_reg   <= ST_IDLE;
      op_cnt_reg  <= 32'h0;
      lat_cnt_reg <= 16'h0;
      kind_reg    <= `FES_KIND_4K;
      base_reg    <= 24'h000000;
      latch_reg   <= 1'b0;
      suspend_reg <= 1'b0;
      done_reg    <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (erase_ok) begin
            state_reg  <= ST_RUN;
            latch_reg  <= 1'b0;
            kind_reg   <= new_kind;
            base_reg   <= new_base;
            op_cnt_reg <= new_cnt;
          end else if (I_PROG_START && latch_reg && !suspend_reg) begin
            state_reg  <= ST_RUN;
            latch_reg  <= 1'b0;
            kind_reg   <= `FES_KIND_PROG;
            op_cnt_reg <= C_PROG;
          end else if (cs_rise && bare_end &&
                       op_reg == `FES_OP_RESUME && suspend_reg) begin
            // Flag clears and busy returns on the next edge
            suspend_reg <= 1'b0;
            state_reg <= ST_RUN;
          end else if (cs_rise && bare_end &&
                       op_reg == `FES_OP_DEEPPD) begin
            state_reg   <= ST_PDENTER;
            lat_cnt_reg <= C_DP;
          end else if (cs_rise && bare_end &&
                       op_reg == `FES_OP_WR_ENABLE) begin
            latch_reg <= 1'b1;
          end
        end
        ST_RUN: begin
          // Suspend only for block erase or program
          if (cs_rise && bare_end && op_reg == `FES_OP_SUSPEND &&
              !suspend_reg && kind_reg != `FES_KIND_CHIP) begin
            // Flag at once, busy falls after latency
            suspend_reg <= 1'b1;
            state_reg   <= ST_SUSPEND;
            lat_cnt_reg <= C_SUS;
          end else if (op_cnt_reg <= 32'h1) begin
            state_reg <= ST_IDLE;
            done_reg  <= 1'b1;
          end else begin
            op_cnt_reg <= op_cnt_reg - 32'h1;
          end
          // Resume ignored while busy (no branch acts on it)
        end
        ST_SUSPEND: begin
          if (lat_cnt_reg <= 16'h1)
            state_reg <= ST_IDLE;
          else
            lat_cnt_reg <= lat_cnt_reg - 16'h1;
        end
        ST_PDENTER: begin
          if (lat_cnt_reg <= 16'h1)
            state_reg <= ST_DEEP;
          else
            lat_cnt_reg <= lat_cnt_reg - 16'h1;
        end
        ST_DEEP: begin
          // Only release honoured; bare or with dummies
          if (cs_rise && bit_cnt_reg == 3'h0 &&
              byte_cnt_reg != 3'h0 && op_reg == `FES_OP_RELEASE) begin
            state_reg   <= ST_RELEASE;
            lat_cnt_reg <= C_RES1;
          end
        end
        ST_RELEASE: begin
          if (lat_cnt_reg <= 16'h1)
            state_reg <= ST_IDLE;
          else
            lat_cnt_reg <= lat_cnt_reg - 16'h1;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // =========================================================
  // Read data path
  wire [7:0] sr1 = {6'h00, latch_reg, busy};
  wire [7:0] sr2 = {suspend_reg, 7'h00};
  wire       id_phase = byte_cnt_reg[2];
  reg  [7:0] cur_byte;
  reg        rd_en;

  always @* begin
    cur_byte = sr1;
    rd_en    = 1'b0;
    if (!deep) begin
      case (op_reg)
        `FES_OP_RDSR1: begin
          cur_byte = sr1;
          rd_en    = byte_cnt_reg != 3'h0;
        end
        `FES_OP_RDSR2: begin
          cur_byte = sr2;
          rd_en    = byte_cnt_reg != 3'h0;
        end
        `FES_OP_MFGID: begin
          cur_byte = (byte_cnt_reg[0] ^ addr_reg[0]) ? P_DEV_ID : P_MFG_ID;
          rd_en    = id_phase;
        end
        `FES_OP_RELEASE: begin
          cur_byte = P_DEV_ID;
          rd_en    = id_phase && !I_QUAD_COMMAND_MODE && !busy;
        end
        default: begin
          rd_en = 1'b0;
        end
      endcase
    end
  end

  reg so_reg;
  reg so_oe_reg;

  always @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      so_reg    <= 1'b0;
      so_oe_reg <= 1'b0;
    end else if (!cs_low) begin
      so_oe_reg <= 1'b0;
    end else if (sck_dn) begin
      // MSB first on falling edges
      so_reg    <= cur_byte[~bit_cnt_reg];
      so_oe_reg <= rd_en;
    end
  end

  assign O_SO                 = so_reg;
  assign O_SO_OE              = so_oe_reg;
  assign O_BUSY               = busy;
  assign O_WRITE_ENABLE_LATCH = latch_reg;
  assign O_SUSPEND_FLAG       = suspend_reg;
  assign O_DEEP_POWER_DOWN    = state_reg == ST_DEEP;
  assign O_PROG_ALLOW         = latch_reg && (state_reg == ST_IDLE) &&
                                !suspend_reg;
  // Status writes refused while suspended or busy
  assign O_STATUS_WRITE_ALLOW = (state_reg == ST_IDLE) && !suspend_reg;
  assign O_OP_DONE            = done_reg;
  assign O_OP_KIND            = kind_reg;
  assign O_ERASE_BASE         = base_reg;

endmodule // fes_core

/* File: sim/fes_core_properties.sv */
// Concurrent checks on the sequencer's ports
`timescale 1ns/10ps
module fes_core_props (
  input wire        I_CLOCK,
  input wire        I_RST_N,
  input wire        I_SCK,
  input wire        I_CS_N,
  input wire        I_SI,
  input wire        I_QUAD_COMMAND_MODE,
  input wire        I_PROG_START,
  input wire        O_SO,
  input wire        O_SO_OE,
  input wire        O_BUSY,
  input wire        O_WRITE_ENABLE_LATCH,
  input wire        O_SUSPEND_FLAG,
  input wire        O_DEEP_POWER_DOWN,
  input wire        O_PROG_ALLOW,
  input wire        O_STATUS_WRITE_ALLOW,
  input wire        O_OP_DONE,
  input wire [2:0]  O_OP_KIND,
  input wire [23:0] O_ERASE_BASE
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  a_busy_drops_wel:
    assert property ($rose(O_BUSY) && !$past(O_SUSPEND_FLAG) |->
      !O_WRITE_ENABLE_LATCH) else $error("latch set as busy rose");
  a_busy_end_done:
    assert property ($fell(O_BUSY) && !O_SUSPEND_FLAG |->
      ##[0:1] (O_OP_DONE || $past(O_OP_DONE))) else $error("no done");
  a_done_pulse:
    assert property (O_OP_DONE |=> !O_OP_DONE) else $error("done too long");
  a_sus_drops_busy:
    assert property ($rose(O_SUSPEND_FLAG) |-> ##[0:401] !O_BUSY)
      else $error("busy kept past suspend latency");
  a_sus_blocks_wr:
    assert property (O_SUSPEND_FLAG |-> !O_STATUS_WRITE_ALLOW &&
      !O_PROG_ALLOW) else $error("write allowed in suspend");
  a_resume_busy:
    assert property ($fell(O_SUSPEND_FLAG) |-> O_BUSY)
      else $error("resume without busy");
  a_deep_is_quiet:
    assert property (O_DEEP_POWER_DOWN |-> !O_BUSY && !O_SO_OE)
      else $error("activity in deep power-down");
  a_chip_base_zero:
    assert property (O_OP_DONE && O_OP_KIND == 3'h3 |->
      O_ERASE_BASE == 24'h000000) else $error("chip erase base");
  a_base_aligned:
    assert property (O_OP_DONE && O_OP_KIND < 3'h3 |->
      O_ERASE_BASE[11:0] == 12'h000) else $error("block base low bits");
  a_so_idle:
    assert property (I_CS_N [*8] |-> !O_SO_OE)
      else $error("output driven while deselected");
  a_prog_needs_wel:
    assert property (O_PROG_ALLOW |-> O_WRITE_ENABLE_LATCH && !O_BUSY)
      else $error("program allowed without latch");
endmodule // fes_core_props
bind fes_core fes_core_props u_props (.*);

/* File: sim/fes_core_test.sv */
// Self-checking bench for the erase, suspend, power-down and ID sequencer
`timescale 1ns/10ps
`include "fes_defs.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module fes_core_test;
  // Identity bytes: arbitrary values
  localparam logic [7:0] MFG = 8'ha5;
  localparam logic [7:0] DEV = 8'h3c;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        quad = 1'b0;
  logic        prog = 1'b0;
  logic [15:0] r;
  int          error_cnt = 0;
  int          checked = 0;
  wire         sck, cs_n, si, so, so_oe, busy, lat, susp, deep, pa, swa, done;
  wire  [2:0]  kind;
  wire  [23:0] base;
  logic [7:0]  ops [5] = '{`FES_OP_ERASE4K, `FES_OP_ERASE32K,
                           `FES_OP_ERASE64K, `FES_OP_CHIPA, `FES_OP_CHIPB};
  logic [2:0]  kinds [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h3};
  logic [23:0] bases [5] = '{24'h012000, 24'h010000, 24'h010000, 0, 0};
  always #25 clk = ~clk;
  fes_core #(.P_SMALL_ERASE_US(5), .P_MID_ERASE_US(100),
    .P_LARGE_ERASE_US(5), .P_FULL_ERASE_US(50), .P_PROG_US(100),
    .P_MFG_ID(MFG), .P_DEV_ID(DEV)) DUT (
    .I_CLOCK(clk), .I_RST_N(rst_n), .I_SCK(sck), .I_CS_N(cs_n), .I_SI(si),
    .I_QUAD_COMMAND_MODE(quad), .I_PROG_START(prog), .O_SO(so),
    .O_SO_OE(so_oe), .O_BUSY(busy), .O_WRITE_ENABLE_LATCH(lat),
    .O_SUSPEND_FLAG(susp), .O_DEEP_POWER_DOWN(deep), .O_PROG_ALLOW(pa),
    .O_STATUS_WRITE_ALLOW(swa), .O_OP_DONE(done), .O_OP_KIND(kind),
    .O_ERASE_BASE(base));
  fes_host_model host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so),
    .i_so_oe(so_oe));
  // ==========================================================
  // Access tasks
  task automatic op(input logic [7:0] c);
    host.xfer({c, 24'h0}, 8, 0, r);
  endtask
  task automatic wait_done(input logic [2:0] ek, input logic [23:0] eb);
    int i;
    i = 0;
    while (done !== 1'b1 && i < 2200) begin
      @(posedge clk);
      #1 i++;
    end
    `CHK("done", 1'b1, done)
    `CHK("kind", ek, kind)
    if (ek !== `FES_KIND_PROG) `CHK("base", eb, base)
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #3000000 error_cnt++;
    stop_test;
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int j = 0; j < 5; j++) begin
      op(`FES_OP_WR_ENABLE);
      `CHK("latch", 1'b1, lat)
      host.xfer({ops[j], 24'h012345}, (j < 3) ? 32 : 8, 0, r);
      `CHK("busy", 1'b1, busy)
      `CHK("latch clr", 1'b0, lat)
      wait_done(kinds[j], bases[j]);
    end
    $display("test erase codes done");
    host.xfer({`FES_OP_ERASE4K, 24'h0}, 32, 0, r);
    `CHK("no latch", 1'b0, busy)
    op(`FES_OP_WR_ENABLE);
    host.xfer({`FES_OP_ERASE4K, 24'h0}, 31, 0, r);
    `CHK("short frame", 1'b0, busy)
    op(`FES_OP_RESUME);
    `CHK("resume idle", 1'b0, busy)
    op(`FES_OP_SUSPEND);
    `CHK("suspend idle", 1'b0, susp)
    $display("test refusals done");
    host.xfer({`FES_OP_ERASE32K, 24'h0}, 32, 0, r);
    host.xfer({`FES_OP_RDSR1, 24'h0}, 8, 16, r);
    `CHK("status", 16'h0101, r)
    op(`FES_OP_SUSPEND);
    `CHK("sus flag", 1'b1, susp)
    repeat (400) @(posedge clk);
    #1 `CHK("sus busy", 1'b0, busy)
    op(`FES_OP_WR_ENABLE);
    host.xfer({`FES_OP_ERASE4K, 24'h0}, 32, 0, r);
    `CHK("erase in sus", 1'b0, busy)
    `CHK("swr in sus", 1'b0, swa)
    host.xfer({`FES_OP_RDSR2, 24'h0}, 8, 16, r);
    `CHK("status2", 16'h8080, r)
    op(`FES_OP_RESUME);
    `CHK("res flag", 1'b0, susp)
    `CHK("res busy", 1'b1, busy)
    wait_done(`FES_KIND_32K, 24'h0);
    op(`FES_OP_WR_ENABLE);
    op(`FES_OP_CHIPA);
    op(`FES_OP_SUSPEND);
    `CHK("chip no sus", 1'b0, susp)
    wait_done(`FES_KIND_CHIP, 24'h0);
    op(`FES_OP_WR_ENABLE);
    @(posedge clk) prog <= 1'b1;
    @(posedge clk) prog <= 1'b0;
    op(`FES_OP_SUSPEND);
    `CHK("prog sus", 1'b1, susp)
    `CHK("prog allow", 1'b0, pa)
    #25000 op(`FES_OP_RESUME);
    wait_done(`FES_KIND_PROG, 24'h0);
    op(`FES_OP_WR_ENABLE);
    host.xfer({`FES_OP_ERASE32K, 24'h0}, 32, 0, r);
    op(`FES_OP_SUSPEND);
    @(posedge clk) rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 `CHK("sus lost", 1'b0, susp)
    op(`FES_OP_RESUME);
    `CHK("no resume", 1'b0, busy)
    $display("test suspend done");
    host.xfer({`FES_OP_DEEPPD, 24'h0}, 9, 0, r);
    `CHK("deep 9 bits", 1'b0, deep)
    op(`FES_OP_DEEPPD);
    repeat (60) @(posedge clk);
    #1 `CHK("deep", 1'b1, deep)
    host.xfer({`FES_OP_RDSR1, 24'h0}, 8, 16, r);
    `CHK("deep status", 1'b0, host.oe_seen)
    op(`FES_OP_WR_ENABLE);
    `CHK("deep latch", 1'b0, lat)
    op(`FES_OP_RELEASE);
    `CHK("release", 1'b0, deep)
    #4000 op(`FES_OP_WR_ENABLE);
    `CHK("after rel", 1'b1, lat)
    $display("test power-down done");
    host.xfer({`FES_OP_RELEASE, 24'h0}, 32, 16, r);
    `CHK("dev id", {DEV, DEV}, r)
    host.xfer({`FES_OP_MFGID, 24'h0}, 32, 16, r);
    `CHK("ids 0", {MFG, DEV}, r)
    host.xfer({`FES_OP_MFGID, 24'h1}, 32, 16, r);
    `CHK("ids 1", {DEV, MFG}, r)
    @(posedge clk) quad <= 1'b1;
    host.xfer({`FES_OP_RELEASE, 24'h0}, 32, 16, r);
    `CHK("quad id", 1'b0, host.oe_seen)
    @(posedge clk) quad <= 1'b0;
    host.xfer({`FES_OP_ERASE32K, 24'h0}, 32, 0, r);
    host.xfer({`FES_OP_RELEASE, 24'h0}, 32, 16, r);
    `CHK("id busy", 1'b0, host.oe_seen)
    `CHK("busy kept", 1'b1, busy)
    wait_done(`FES_KIND_32K, 24'h0);
    $display("test identification done");
    stop_test;
  end
endmodule // fes_core_test

/* File: sim/fes_host_model.sv */
// Host controller model that drives the serial command link
`timescale 1ns/10ps
module fes_host_model (
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  input  wire  i_so,
  input  wire  i_so_oe
);
  logic oe_seen;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    oe_seen = 1'b0;
  end
  always @(posedge i_so_oe) oe_seen = 1'b1;
  // ==========================================================
  // Frame: n bits out MSB first, then m bits read back
  // select drops, bits, select rises
  task automatic xfer(input logic [31:0] d, input int n, input int m,
                      output logic [15:0] r);
    r = 16'h0000;
    oe_seen = 1'b0;
    o_cs_n = 1'b0;
    for (int i = 0; i < n + m; i++) begin
      if (i < n) o_si = d[31-i];
      else o_si = ~o_si;
      #200 o_sck = 1'b1;
      #100 if (i >= n) r = {r[14:0], i_so};
      #100 o_sck = 1'b0;
    end
    #200 o_cs_n = 1'b1;
    o_si = ~o_si;
    #1000;
  endtask
endmodule // fes_host_model
